//--- verilog/vsu_upsampler.sv
// Purpose: Vector up-sampler, repeats or zero-pads each input sample.
// Assumes: srcEn pulses once per input period, dstEn once per output slot,
//   both high together on the first slot of each input period.
// Notes: Data path is combinational from input (or latency line) to output.
`timescale 1ns/1ns
import vsu_pkg::*;

// Contract
// R1: Output slot period is input period over n.
// R2: Copy repeats n times; zero-fill sends once, n-1 zeros.
// R3: Copy mode wires input straight to output.
// R4: Zero-fill uses mux between sample and zero.
// R5: Surrounding logic supplies slow and fast enables.
// R6: One flop registers slow enable to steer mux.
// R7: Downstream should register the zero-fill output.
// R8: Rate factor is an integer of two or more.
// R9: Enable input only meaningful with positive latency.
// R10: Latency line of L stages on slow enable.
// R11: Deasserted enable freezes latency line contents.
module vsu_upsampler #(
  parameter int RATE = VSU_DEF_RATE,
  parameter int LATENCY = VSU_DEF_LATENCY,
  parameter int VECTOR_LANE_COUNT = VSU_DEF_LANES,
  parameter int SAMPLE_WIDTH = VSU_DEF_WIDTH,
  parameter vsu_fill_t FILL_MODE = VSU_FILL_ZERO
) (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Rate enables from surrounding logic
  input wire logic srcEn,
  input wire logic dstEn,
  // Optional latency-line enable, ignored when LATENCY is zero
  input wire logic en,
  // Sample vector, lane k in bits k*SAMPLE_WIDTH upward
  input wire logic [VECTOR_LANE_COUNT*SAMPLE_WIDTH-1:0] din,
  output logic [VECTOR_LANE_COUNT*SAMPLE_WIDTH-1:0] dout,
  // Avalon-MM slave
  input wire logic [1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);
  localparam int VW = VECTOR_LANE_COUNT * SAMPLE_WIDTH;
  // Factors below two are raised to two
  localparam int EFF_RATE = (RATE < VSU_MIN_RATE) ? VSU_MIN_RATE : RATE; // see R8
  localparam logic [VSU_SLOT_W-1:0] LAST_SLOT = VSU_SLOT_W'(EFF_RATE - 1);

  logic [VW-1:0] sampleVec;
  logic selData_q;
  logic [VSU_SLOT_W-1:0] slot_q;
  logic [VSU_SLOT_W-1:0] slot_d;
  logic [VSU_CNT_W-1:0] frames_q;
  logic [VSU_CNT_W-1:0] frames_d;
  logic countEn_q;
  logic clearReq;
  vsu_bus_state_t busState_q;
  logic [31:0] readData_d;
  logic [31:0] readData_q;
  logic busReq;
  logic busTake;
  logic hitCtrl;
  logic hitStatus;
  logic hitFrames;

  // Input latency line, advancing once per input period
  if (LATENCY > 0) begin : gLatency
    logic lineAdvance;
    assign lineAdvance = srcEn & en; // see R10, see R11, see R9
    vsu_delay_line #(
      .DEPTH(LATENCY),
      .WIDTH(VW)
    ) uDelay (
      .clock(clock),
      .sys_rst(sys_rst),
      .advance(lineAdvance),
      .dataIn(din),
      .dataOut(sampleVec)
    );
  end else begin : gNoLatency
    assign sampleVec = din; // enable input unused in this build, see R9
  end

  // Output data path
  if (FILL_MODE == VSU_FILL_COPY) begin : gCopy
    assign dout = sampleVec; // see R3, see R2
    assign selData_q = 1'b1;
  end else begin : gZero
    // Slow enable delayed to the fast rate, high for the first slot only
    always_ff @(posedge clock) begin
      if (sys_rst) begin
        selData_q <= 1'b0;
      end else if (dstEn) begin
        selData_q <= srcEn; // see R6, see R5
      end
    end
    // Per-lane mux between sample and zero; output is combinational, see R7
    for (genvar k = 0; k < VECTOR_LANE_COUNT; k++) begin : gLane
      assign dout[k*SAMPLE_WIDTH +: SAMPLE_WIDTH] =
        selData_q ? sampleVec[k*SAMPLE_WIDTH +: SAMPLE_WIDTH] : '0; // see R4, see R2
    end
  end

  // Output slot position within the input frame, n slots per frame
  assign slot_d = (dstEn & srcEn) ? '0 :
                  (dstEn & (slot_q != LAST_SLOT)) ? slot_q + 1'b1 : slot_q; // see R1

  // Input frame counter, clear with a counted frame in the same cycle restarts the count at one
  assign frames_d = (countEn_q & srcEn) ? (clearReq ? VSU_CNT_W'(1) : frames_q + 1'b1) :
                    (clearReq ? '0 : frames_q);

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      slot_q <= '0;
      frames_q <= '0;
    end else begin
      slot_q <= slot_d;
      frames_q <= frames_d;
    end
  end

  // Bus decode
  assign busReq = avs_read | avs_write;
  assign busTake = (busState_q == VSU_BUS_ACK) & avs_write;
  assign hitCtrl = (avs_address == VSU_ADDR_CTRL);
  assign hitStatus = (avs_address == VSU_ADDR_STATUS);
  assign hitFrames = (avs_address == VSU_ADDR_FRAMES);
  assign clearReq = busTake & hitCtrl & avs_writedata[VSU_CTRL_CLEAR_BIT];

  // Read mux, unmapped words read as zero
  always_comb begin
    readData_d = VSU_READ_ZERO;
    if (hitCtrl) begin
      readData_d[VSU_CTRL_COUNT_EN_BIT] = countEn_q;
    end else if (hitStatus) begin
      readData_d[VSU_SLOT_W-1:0] = slot_q;
      readData_d[VSU_STAT_SEL_BIT] = selData_q;
      readData_d[VSU_STAT_MODE_BIT] = FILL_MODE;
    end else if (hitFrames) begin
      readData_d[VSU_CNT_W-1:0] = frames_q;
    end
  end

  // Answer sequencer: one wait cycle, then a single acknowledge cycle
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      busState_q <= VSU_BUS_IDLE;
      avs_waitrequest <= 1'b1;
      readData_q <= '0;
    end else begin
      case (busState_q)
        VSU_BUS_IDLE: begin
          if (busReq) begin
            busState_q <= VSU_BUS_ACK;
            avs_waitrequest <= 1'b0;
            readData_q <= readData_d;
          end
        end
        default: begin
          busState_q <= VSU_BUS_IDLE;
          avs_waitrequest <= 1'b1;
        end
      endcase
    end
  end

  assign avs_readdata = readData_q;

  // Control register
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      countEn_q <= VSU_CTRL_COUNT_EN_RESET;
    end else if (busTake & hitCtrl) begin
      countEn_q <= avs_writedata[VSU_CTRL_COUNT_EN_BIT];
    end
  end
endmodule

//--- verilog/vsu_pkg.sv
// Purpose: Shared constants and types of the vector up-sampler.
// Assumes: One fabric clock, samples qualified by two clock enables.
// Notes: Bus offsets are word addresses on a 32-bit Avalon-MM slave.
package vsu_pkg;
  // Sample insertion style
  typedef enum logic [0:0] {
    VSU_FILL_ZERO = 1'b0,
    VSU_FILL_COPY = 1'b1
  } vsu_fill_t;

  // Bus answer sequencer
  typedef enum logic [0:0] {
    VSU_BUS_IDLE = 1'b0,
    VSU_BUS_ACK = 1'b1
  } vsu_bus_state_t;

  // Documented defaults
  localparam int VSU_DEF_RATE = 2;
  localparam int VSU_MIN_RATE = 2;
  localparam int VSU_DEF_LATENCY = 0;
  localparam int VSU_DEF_LANES = 4;
  localparam int VSU_DEF_WIDTH = 16;
  localparam int VSU_CNT_W = 16;
  localparam int VSU_SLOT_W = 16;

  // Register word addresses
  localparam logic [1:0] VSU_ADDR_CTRL = 2'h0;
  localparam logic [1:0] VSU_ADDR_STATUS = 2'h1;
  localparam logic [1:0] VSU_ADDR_FRAMES = 2'h2;

  // Control fields
  localparam int VSU_CTRL_COUNT_EN_BIT = 0;
  localparam int VSU_CTRL_CLEAR_BIT = 1;
  localparam logic VSU_CTRL_COUNT_EN_RESET = 1'b1;

  // Status fields
  localparam int VSU_STAT_SEL_BIT = 16;
  localparam int VSU_STAT_MODE_BIT = 17;
  localparam logic [31:0] VSU_READ_ZERO = 32'h00000000;
endpackage

//--- verilog/vsu_delay_line.sv
// Purpose: Input latency line, a chain of enabled sample registers.
// Assumes: DEPTH of at least one; caller bypasses it for zero latency.
// Notes: Output comes from the last stage register.
`timescale 1ns/1ns
module vsu_delay_line #(
  parameter int DEPTH = 1,
  parameter int WIDTH = 64
) (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Stage advance
  input wire logic advance,
  // Data
  input wire logic [WIDTH-1:0] dataIn,
  output logic [WIDTH-1:0] dataOut
);
  logic [WIDTH-1:0] stage_q [DEPTH];

  // One register per stage, all moving together on advance
  for (genvar i = 0; i < DEPTH; i++) begin : gStage
    always_ff @(posedge clock) begin
      if (sys_rst) begin
        stage_q[i] <= '0;
      end else if (advance) begin
        stage_q[i] <= (i == 0) ? dataIn : stage_q[(i == 0) ? 0 : i - 1];
      end
    end
  end

  assign dataOut = stage_q[DEPTH-1];
endmodule

//--- verif/vsu_upsampler_sva.sv
// Purpose: Port checks of the up-sampler.
// Assumes: Zero-fill build, one latency stage.
// Notes: Bound to the top module.
`timescale 1ns/1ns
module vsu_upsampler_sva #(parameter int W = 64) (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Data path
  input wire logic srcEn,
  input wire logic dstEn,
  input wire logic en,
  input wire logic [W-1:0] din,
  input wire logic [W-1:0] dout,
  // Register bus
  input wire logic [1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  // Data path
  a_reset_idle: assert property ($fell(sys_rst) |-> avs_waitrequest && dout == '0)
    else $error("bad state after reset");
  a_slot_sample: assert property (srcEn && dstEn && en |=> dout == $past(din))
    else $error("first slot lacks sample");
  a_slot_hold: assert property (srcEn && dstEn && en |=> ##1 $stable(dout))
    else $error("sample slot not held");
  a_zero_fill: assert property (dstEn && !srcEn |=> dout == '0)
    else $error("inserted slot not zero");
  // Register bus
  a_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("answer not after one wait");
  a_ack_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("acknowledge too long");
  a_no_spont: assert property (!avs_read && !avs_write && avs_waitrequest |=> avs_waitrequest)
    else $error("acknowledge without request");
  a_unmapped_zero: assert property (avs_read && avs_address == 2'h3 && avs_waitrequest
    |=> avs_readdata == 32'h0) else $error("unmapped read not zero");
  c_frozen: cover property (srcEn && !en);
  c_write: cover property (avs_write && !avs_waitrequest);
  c_sample: cover property (srcEn && dstEn && en);
endmodule
bind vsu_upsampler vsu_upsampler_sva #(.W(VECTOR_LANE_COUNT*SAMPLE_WIDTH)) chk (.*);

//--- verif/vsu_rate_model.sv
// Purpose: Upstream source of enables and samples.
// Assumes: Fast slot every second cycle.
// Notes: Sample steps at each frame start, then holds.
`timescale 1ns/1ns
module vsu_rate_model #(parameter int RATE = 3) (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Toward the up-sampler
  output logic srcEn,
  output logic dstEn,
  output logic [63:0] din
);
  int slot = 0;
  initial begin
    srcEn = 1'b0;
    dstEn = 1'b0;
    din = 64'h0;
  end
  // Slow enable on every RATE-th fast slot
  always @(posedge clock) begin
    dstEn <= !sys_rst && !dstEn;
    srcEn <= !sys_rst && !dstEn && slot == 0;
    if (sys_rst) slot <= 0;
    else if (!dstEn) slot <= (slot == RATE - 1) ? 0 : slot + 1;
    if (!sys_rst && !dstEn && slot == 0) din <= din + 64'h0101_2323_4545_6767;
  end
endmodule

//--- verif/vsu_upsampler_tb_top.sv
// Purpose: Self-checking bench of the up-sampler.
// Assumes: RATE 3, one latency stage, zero fill.
// Notes: Reference compared with dout every cycle.
`timescale 1ns/1ns
module vsu_upsampler_tb_top;
  import vsu_pkg::*;
  logic clock = 1'b0, sys_rst = 1'b1, en = 1'b1, srcEn, dstEn, expSel = 1'b0;
  logic [63:0] din, dout, expLine = 64'h0, doutReg = 64'h0, expReg = 64'h0;
  logic [1:0] avs_address = 2'h0;
  logic avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
  int mismatches = 0, comparisons = 0;
  vsu_upsampler #(.RATE(3), .LATENCY(1), .FILL_MODE(VSU_FILL_ZERO)) DUT (.*);
  vsu_rate_model #(.RATE(3)) src (.clock, .sys_rst, .srcEn, .dstEn, .din);
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One Avalon access, held until waitrequest is low
  task automatic bus(input logic wr, input logic [1:0] a, input logic [31:0] d);
    @(posedge clock);
    avs_address <= a;
    avs_read <= !wr;
    avs_write <= wr;
    avs_writedata <= d;
    do @(posedge clock); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Reference line stage and slot selector
  always @(posedge clock) begin
    expLine <= sys_rst ? 64'h0 : (srcEn && en) ? din : expLine;
    expSel <= sys_rst ? 1'b0 : dstEn ? srcEn : expSel;
    // Downstream register behind the combinational output
    doutReg <= dout;
    expReg <= sys_rst ? 64'h0 : expSel ? expLine : 64'h0;
  end
  always @(negedge clock) begin
    if (!sys_rst) check(dout, expSel ? expLine : 64'h0);
    if (!sys_rst) check(doutReg, expReg);
  end
  initial forever #5 clock = ~clock;
  initial begin
    #20000;
    mismatches++;
    close_out();
  end
  initial begin
    repeat (12) @(posedge clock);
    sys_rst <= 1'b0;
    bus(1'b0, VSU_ADDR_CTRL, 32'h0);
    check(rd, 32'h1);
    bus(1'b1, 2'h3, 32'h0);
    bus(1'b0, 2'h3, 32'h0);
    check(rd, 32'h0);
    bus(1'b0, VSU_ADDR_STATUS, 32'h0);
    check(rd[VSU_STAT_MODE_BIT], 1'b0);
    // Stop counting, clear, and check the frame counter holds zero
    bus(1'b1, VSU_ADDR_CTRL, 32'h0);
    bus(1'b1, VSU_ADDR_CTRL, 32'h2);
    bus(1'b0, VSU_ADDR_CTRL, 32'h0);
    check(rd, 32'h0);
    repeat (10) @(posedge clock);
    bus(1'b0, VSU_ADDR_FRAMES, 32'h0);
    check(rd, 32'h0);
    bus(1'b1, VSU_ADDR_CTRL, 32'h1);
    repeat (20) @(posedge clock);
    bus(1'b0, VSU_ADDR_FRAMES, 32'h0);
    check(rd == 32'h0, 1'b0);
    repeat (30) @(posedge clock);
    en <= 1'b0;
    repeat (40) @(posedge clock);
    en <= 1'b1;
    repeat (30) @(posedge clock);
    close_out();
  end
endmodule
